// [core/fts_regs.svh]
// Constants of the flow-through synchronous memory core.
// Assumes inclusion by bare name from the core files.
`ifndef FTS_REGS_SVH
`define FTS_REGS_SVH
// Address and lane widths
`define FTS_ADDR_W 19
`define FTS_LANE_W 9
// Write buffer depth in words
`define FTS_BUF_DEPTH 16
// Sleep entry and wake settle windows, in clock cycles
`define FTS_SLEEP_SETTLE 2
`define FTS_WAKE_SETTLE 2
// Cycle counts derived from the windows (unit is already cycles)
`define FTS_SLEEP_CYC (`FTS_SLEEP_SETTLE)
`define FTS_WAKE_CYC (`FTS_WAKE_SETTLE)
`endif

// [core/fts_pkg.sv]
// Types shared by the memory core files.
// Assumes the constants header is compiled alongside.
package fts_pkg;
    // Burst state of the memory
    typedef enum logic [1:0] {
        FTS_IDLE,
        FTS_DESEL,
        FTS_READ,
        FTS_WRITE
    } fts_state_t;
endpackage : fts_pkg

// [core/fts_fifo.sv]
// Write buffer FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/100ps
module fts_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    // Storage words
    logic [WIDTH-1:0] mem [DEPTH];
    // Pointers carry one wrap bit
    logic [PW:0] wr_ptr;
    logic [PW:0] rd_ptr;
    logic full;
    logic empty;

    assign empty = (wr_ptr == rd_ptr);
    assign full = (wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_ptr[PW-1:0]];

    ////////////////////////////////////////////////////////////////////////
    // Fill side
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
        end else if (in_valid && !full) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    // Storage write, no reset needed
    always_ff @(posedge mclk) begin
        if (in_valid && !full) begin
            mem[wr_ptr[PW-1:0]] <= in_data;
        end
    end

    // Drain side
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_ptr <= '0;
        end else if (out_ready && !empty) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule : fts_fifo

// [core/fts_burst.sv]
// Two-bit burst address counter, linear or interleaved order.
// Assumes load and step are never high together.
`timescale 1ns/100ps
module fts_burst (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic step,
    input wire logic [1:0] start_in,
    input wire logic linear,
    output logic [1:0] start,
    output logic [1:0] count,
    output logic [1:0] next_low
);
    logic [1:0] count_inc;

    // Wraps to the start after four cycles by width alone
    assign count_inc = count + 2'h1;
    assign next_low = linear ? 2'(start + count_inc) : (start ^ count_inc);

    ////////////////////////////////////////////////////////////////////////
    // two-bit count, load restarts
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            start <= 2'h0;
            count <= 2'h0;
        end else if (load) begin
            start <= start_in;
            count <= 2'h0;
        end else if (step) begin
            count <= count_inc;
        end
    end
endmodule : fts_burst

// [core/fts_core.sv]
// Flow-through synchronous memory with late write and snooze.
// Assumes synchronous pins are timed to mclk; sleep, output enable
// and order select are asynchronous and synchronised here.
`timescale 1ns/100ps
`include "fts_regs.svh"

module fts_core #(
    parameter int ADDR_W = `FTS_ADDR_W,
    parameter int LANE_W = `FTS_LANE_W,
    parameter int BUF_DEPTH = `FTS_BUF_DEPTH
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sleep_request,
    input wire logic chip_select_low_first,
    input wire logic chip_select_high,
    input wire logic chip_select_low_second,
    input wire logic advance_or_load,
    input wire logic read_not_write,
    input wire logic byte_lane_a_write_n,
    input wire logic byte_lane_b_write_n,
    input wire logic clock_hold_n,
    input wire logic output_enable_n,
    input wire logic linear_order_select_n,
    input wire logic [ADDR_W-1:0] address,
    input wire logic [LANE_W-1:0] data_lane_a_in,
    output logic [LANE_W-1:0] data_lane_a_out,
    output logic data_lane_a_oe,
    input wire logic [LANE_W-1:0] data_lane_b_in,
    output logic [LANE_W-1:0] data_lane_b_out,
    output logic data_lane_b_oe,
    output logic sleeping,
    output logic buffer_ready
);
    import fts_pkg::*;

    localparam int BUF_W = ADDR_W + 2 + 2 * LANE_W;

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [2*LANE_W-1:0] mem [2**ADDR_W]; // Storage array
    logic slp_m, slp_s; // Sleep synchroniser
    logic oe_m, oe_s; // Output enable synchroniser
    logic ord_m, ord_s; // Order select synchroniser
    logic [1:0] wake_cnt; // Wake settle countdown
    logic active; // Inputs are sampled
    fts_state_t state; // Burst state
    logic [ADDR_W-3:0] upper; // Latched upper address
    logic [1:0] burst_low; // Low bits last used
    logic [1:0] b_start, b_count, b_next;
    logic wr_pend; // Write data due next edge
    logic [ADDR_W-1:0] wr_addr;
    logic [1:0] wr_be_n;
    logic buf_in_ready, buf_out_valid, buf_out_ready;
    logic [BUF_W-1:0] buf_out;
    logic stall, en, load, step, desel, any_be;
    logic read_now, wr_now, next_drive, drive;
    logic [1:0] cyc_low;
    logic [ADDR_W-1:0] cyc_addr;
    logic [ADDR_W-1:0] dr_addr;
    logic [1:0] dr_be_n;
    logic [LANE_W-1:0] dr_a, dr_b;

    ////////////////////////////////////////////////////////////////////////
    // Asynchronous inputs pass two flops
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            slp_m <= 1'b0;
            slp_s <= 1'b0;
            oe_m <= 1'b1;
            oe_s <= 1'b1;
            ord_m <= 1'b1;
            ord_s <= 1'b1;
        end else begin
            slp_m <= sleep_request;
            slp_s <= slp_m;
            oe_m <= output_enable_n;
            oe_s <= oe_m;
            ord_m <= linear_order_select_n;
            ord_s <= ord_m;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wake_cnt <= 2'h0;
        end else if (slp_s) begin
            wake_cnt <= 2'(`FTS_WAKE_CYC);
        end else if (wake_cnt != 2'h0) begin
            wake_cnt <= wake_cnt - 2'h1;
        end
    end

    // entry within two edges via synchroniser
    assign active = !slp_s && (wake_cnt == 2'h0);

    ////////////////////////////////////////////////////////////////////////
    // Cycle decode
    // any inactive chip select deselects
    assign desel = chip_select_low_first || !chip_select_high || chip_select_low_second;
    assign any_be = !(byte_lane_a_write_n && byte_lane_b_write_n);
    // Full buffer with data due holds the whole pipeline one cycle
    assign stall = wr_pend && !buf_in_ready;
    assign en = active && !clock_hold_n && !stall;
    assign load = en && !advance_or_load;
    // continue steps only inside a burst
    assign step = en && advance_or_load && (state == FTS_READ || state == FTS_WRITE);
    assign cyc_low = advance_or_load ? b_next : address[1:0];
    assign cyc_addr = advance_or_load ? {upper, b_next} : address;
    // read happens; dummy reads only lose the drive
    assign read_now = (load && !desel && read_not_write) || (step && state == FTS_READ);
    // write only with a lane enabled
    assign wr_now = any_be && ((load && !desel && !read_not_write)
                               || (step && state == FTS_WRITE));

    // Driver decision for the next cycle
    always_comb begin
        next_drive = 1'b0;
        if (!active) begin
            next_drive = 1'b0;
        end else if (!en) begin
            next_drive = drive;
        end else if (!advance_or_load) begin
            next_drive = !desel && read_not_write;
        end else begin
            next_drive = (state == FTS_READ);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Burst state
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= FTS_IDLE;
        end else if (!active) begin
            state <= FTS_DESEL;
        end else if (load) begin
            if (desel) begin
                state <= FTS_DESEL;
            end else if (read_not_write) begin
                state <= FTS_READ;
            end else begin
                state <= FTS_WRITE;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            upper <= '0;
            burst_low <= 2'h0;
        end else if (load && !desel) begin
            upper <= address[ADDR_W-1:2];
            burst_low <= cyc_low;
        end else if (step) begin
            burst_low <= cyc_low;
        end
    end

    fts_burst u_burst (
        .mclk(mclk),
        .rst_n(rst_n),
        .load(load && !desel),
        .step(step),
        .start_in(address[1:0]),
        .linear(!ord_s),
        .start(b_start),
        .count(b_count),
        .next_low(b_next)
    );

    ////////////////////////////////////////////////////////////////////////
    // late write: command now, data next enabled edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
            wr_be_n <= 2'h3;
        end else if (!active) begin
            // Pending write may be lost at sleep entry
            wr_pend <= 1'b0;
        end else if (en) begin
            wr_pend <= wr_now;
            wr_addr <= cyc_addr;
            wr_be_n <= {byte_lane_b_write_n, byte_lane_a_write_n};
        end
    end

    // Drain yields to reads unless the buffer is full
    assign buf_out_ready = !read_now || !buf_in_ready;

    fts_fifo #(
        .WIDTH(BUF_W),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .mclk(mclk),
        .rst_n(rst_n),
        .in_valid(wr_pend && en),
        .in_ready(buf_in_ready),
        .in_data({wr_addr, wr_be_n, data_lane_b_in, data_lane_a_in}),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(buf_out)
    );

    assign {dr_addr, dr_be_n, dr_b, dr_a} = buf_out;

    // each lane written under its own enable
    always_ff @(posedge mclk) begin
        if (buf_out_valid && buf_out_ready) begin
            if (!dr_be_n[0]) begin
                mem[dr_addr][LANE_W-1:0] <= dr_a;
            end
            if (!dr_be_n[1]) begin
                mem[dr_addr][2*LANE_W-1:LANE_W] <= dr_b;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, valid the cycle after the command edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            data_lane_a_out <= '0;
            data_lane_b_out <= '0;
        end else if (read_now) begin
            {data_lane_b_out, data_lane_a_out} <= mem[cyc_addr];
        end
    end

    // drivers off from reset; output enable gates
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            drive <= 1'b0;
            data_lane_a_oe <= 1'b0;
            data_lane_b_oe <= 1'b0;
            sleeping <= 1'b0;
            buffer_ready <= 1'b1;
        end else begin
            drive <= next_drive;
            data_lane_a_oe <= next_drive && !oe_s;
            data_lane_b_oe <= next_drive && !oe_s;
            sleeping <= slp_s;
            buffer_ready <= buf_in_ready;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_sleep_hiz;
        @(posedge mclk) disable iff (!rst_n) slp_s |=> !data_lane_a_oe && !data_lane_b_oe;
    endproperty
    a_sleep_hiz: assert property (p_sleep_hiz) else $error("drive while asleep");

    property p_sleep_desel;
        @(posedge mclk) disable iff (!rst_n) slp_s |=> state == FTS_DESEL && !wr_pend;
    endproperty
    a_sleep_desel: assert property (p_sleep_desel) else $error("not deselected");

    property p_entry;
        @(posedge mclk) disable iff (!rst_n) $rose(sleep_request) |-> ##2 !active;
    endproperty
    a_entry: assert property (p_entry) else $error("sleep entry late");

    property p_wake;
        @(posedge mclk) disable iff (!rst_n) $fell(slp_s) |-> !active [*2];
    endproperty
    a_wake: assert property (p_wake) else $error("woke too early");

    property p_linear;
        @(posedge mclk) disable iff (!rst_n)
            step && !ord_s |=> burst_low == 2'($past(burst_low) + 2'h1);
    endproperty
    a_linear: assert property (p_linear) else $error("linear step wrong");

    property p_inter;
        @(posedge mclk) disable iff (!rst_n)
            step && ord_s |=> (burst_low ^ $past(burst_low)) == {$past(b_count[0]), 1'b1};
    endproperty
    a_inter: assert property (p_inter) else $error("interleave step wrong");

    property p_hold;
        @(posedge mclk) disable iff (!rst_n)
            active && clock_hold_n |=> $stable(state) && $stable(burst_low) && $stable(b_count)
            && $stable(data_lane_a_out) && data_lane_a_oe == $past(drive && !oe_s);
    endproperty
    a_hold: assert property (p_hold) else $error("held edge changed state");

    property p_read;
        @(posedge mclk) disable iff (!rst_n)
            load && !desel && read_not_write && !oe_s |=> data_lane_a_oe && state == FTS_READ;
    endproperty
    a_read: assert property (p_read) else $error("read not driven");

    property p_write_off;
        @(posedge mclk) disable iff (!rst_n) state == FTS_WRITE |-> !data_lane_a_oe;
    endproperty
    a_write_off: assert property (p_write_off) else $error("drive in write");

    property p_abort;
        @(posedge mclk) disable iff (!rst_n) en && !any_be |=> !wr_pend;
    endproperty
    a_abort: assert property (p_abort) else $error("abort scheduled write");

    property p_late;
        @(posedge mclk) disable iff (!rst_n) wr_now |=> wr_pend && wr_addr == $past(cyc_addr);
    endproperty
    a_late: assert property (p_late) else $error("late write lost");

    c_read_burst: cover property (@(posedge mclk) disable iff (!rst_n)
        load && read_not_write && !desel ##1 step [*3]);
    c_write_burst: cover property (@(posedge mclk) disable iff (!rst_n)
        load && !read_not_write && !desel ##1 step [*3]);
    c_sleep: cover property (@(posedge mclk) disable iff (!rst_n) $fell(slp_s) ##3 active);
    c_full: cover property (@(posedge mclk) disable iff (!rst_n) stall);
endmodule : fts_core

// [sim/fts_master.sv]
// Bus master model for the command side of the memory core.
// Assumes the bench calls put once a cycle, just after the rising edge.
`timescale 1ns/100ps
module fts_master #(
    parameter int AW = 8
) (
    output logic chip_select_low_first,
    output logic chip_select_high,
    output logic chip_select_low_second,
    output logic advance_or_load,
    output logic read_not_write,
    output logic byte_lane_a_write_n,
    output logic byte_lane_b_write_n,
    output logic clock_hold_n,
    output logic [AW-1:0] address,
    output logic [8:0] data_lane_a_in,
    output logic [8:0] data_lane_b_in
);
    logic in_wr = 1'b0; // Current burst is a write
    logic pend = 1'b0; // Write data due this cycle
    logic [17:0] pdat = 18'h0; // Data owed for the last write cycle

    ////////////////////////////////////////
    // Idle bus: deselected, running clock
    initial begin
        {chip_select_low_first, chip_select_high, chip_select_low_second} = 3'b101;
        {advance_or_load, read_not_write, byte_lane_b_write_n, byte_lane_a_write_n} = 4'hF;
        clock_hold_n = 1'b0;
        address = '0;
        {data_lane_b_in, data_lane_a_in} = 18'h0;
    end

    ////////////////////////////////////////
    // One bus cycle; sel 0 selects, 1..3 drops one enable
    task automatic put(input logic adv, input logic rnw, input logic [1:0] sel,
                       input logic [1:0] be, input logic [AW-1:0] a,
                       input logic [17:0] wd, input logic hold);
        if (pend) begin
            {data_lane_b_in, data_lane_a_in} = pdat;
        end else begin
            // Released lines toggle so stale data never matches by luck
            {data_lane_b_in, data_lane_a_in} = ~{data_lane_b_in, data_lane_a_in};
        end
        chip_select_low_first = sel == 2'd1;
        chip_select_high = sel != 2'd2;
        chip_select_low_second = sel == 2'd3;
        advance_or_load = adv;
        read_not_write = rnw;
        {byte_lane_b_write_n, byte_lane_a_write_n} = be;
        address = a;
        clock_hold_n = hold;
        if (!hold) begin
            if (!adv) begin
                in_wr = sel == 2'd0 && !rnw;
            end
            pend = in_wr && be != 2'b11;
            pdat = wd;
        end
    endtask : put
endmodule : fts_master

// [sim/test_flowthrough_sync_sram_control.sv]
// Self-checking bench for the memory core against a queue-free model.
// Assumes the master model in the sim folder and the core files.
`timescale 1ns/100ps
module test_flowthrough_sync_sram_control;
    localparam int AW = 8; // Reduced address width
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic sleep_request = 1'b0;
    logic oe_n = 1'b0; // Output enable, active low
    logic lin_n = 1'b0; // Order select, low = linear
    logic cs_lo1, cs_hi, cs_lo2, step_or_load, rnw, lane_a_wr_n, lane_b_wr_n, hold_n;
    logic [AW-1:0] addr;
    logic [8:0] da_in, db_in, da_out, db_out;
    logic da_oe, db_oe, sleeping, buffer_ready;
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;
    // Model state: 0 idle, 1 deselect, 2 read, 3 write
    int st = 0;
    logic [AW-1:0] up = '0, ad = '0, wa = '0;
    logic [1:0] cn = 2'h0, wbe = 2'h3;
    logic e_oe = 1'b0, wp = 1'b0, ck = 1'b0, asleep = 1'b0;
    logic [17:0] wdat = 18'h0;
    logic [17:0] mem [int];
    logic [15:0] lf = 16'h0063;

    always #2.5 mclk = ~mclk;

    fts_master #(.AW(AW)) u_master (.chip_select_low_first(cs_lo1), .chip_select_high(cs_hi),
        .chip_select_low_second(cs_lo2), .advance_or_load(step_or_load), .read_not_write(rnw),
        .byte_lane_a_write_n(lane_a_wr_n), .byte_lane_b_write_n(lane_b_wr_n),
        .clock_hold_n(hold_n),
        .address(addr), .data_lane_a_in(da_in), .data_lane_b_in(db_in));

    fts_core #(.ADDR_W(AW)) DUT (.mclk(mclk), .rst_n(rst_n), .sleep_request(sleep_request),
        .chip_select_low_first(cs_lo1), .chip_select_high(cs_hi),
        .chip_select_low_second(cs_lo2), .advance_or_load(step_or_load), .read_not_write(rnw),
        .byte_lane_a_write_n(lane_a_wr_n), .byte_lane_b_write_n(lane_b_wr_n),
        .clock_hold_n(hold_n),
        .output_enable_n(oe_n), .linear_order_select_n(lin_n), .address(addr),
        .data_lane_a_in(da_in), .data_lane_a_out(da_out), .data_lane_a_oe(da_oe),
        .data_lane_b_in(db_in), .data_lane_b_out(db_out), .data_lane_b_oe(db_oe),
        .sleeping(sleeping), .buffer_ready(buffer_ready));

    ////////////////////////////////////////
    // Hang guard, far above the run length
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            close_out();
        end
    end

    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr

    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic close_out();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out

    ////////////////////////////////////////
    // One cycle: check last answer, drive, step the model
    task automatic cyc(input logic adv, input logic r, input logic [1:0] sel,
                       input logic [1:0] be, input logic [AW-1:0] a, input logic hold);
        logic [17:0] wd;
        @(posedge mclk);
        #1;
        if (ck) begin
            chk({16'h0, da_oe, db_oe}, {16'h0, e_oe, e_oe});
            if (e_oe && mem.exists(int'(ad))) chk({db_out, da_out}, mem[int'(ad)]);
        end
        lf = lfsr(lf);
        wd = {lf[1:0], lf};
        u_master.put(adv, r, sel, be, a, wd, hold);
        if (!hold && !asleep) begin
            // each lane by its own enable
            if (wp && !wbe[0]) mem[int'(wa)][8:0] = wdat[8:0];
            if (wp && !wbe[1]) mem[int'(wa)][17:9] = wdat[17:9];
            if (!adv) begin
                st = sel != 2'd0 ? 1 : (r ? 2 : 3);
                up = a;
                cn = 2'h0;
            end else if (st >= 2) begin
                cn = cn + 2'h1;
            end
            ad = {up[AW-1:2], lin_n ? (up[1:0] ^ cn) : (up[1:0] + cn)};
            wp = st == 3 && be != 2'b11;
            wa = ad;
            wbe = be;
            wdat = wd;
        end
        e_oe = !asleep && (hold ? e_oe : (st == 2 && !oe_n));
    endtask : cyc

    ////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (12) @(posedge mclk);
        #1;
        chk({16'h0, da_oe, db_oe}, 18'h0);
        chk({17'h0, buffer_ready}, 18'h1);
        rst_n = 1'b1;
        ck = 1'b1;
        // Full words at 44..4F; junk selects on continues
        for (int b = 0; b < 3; b++) begin
            cyc(1'b0, 1'b0, 2'd0, 2'b00, AW'(8'h44 + 4 * b), 1'b0);
            repeat (3) cyc(1'b1, 1'b1, 2'd3, 2'b00, '0, 1'b0);
        end
        // lane a, lane b, then an abort that still steps
        cyc(1'b0, 1'b0, 2'd0, 2'b00, 'h45, 1'b0);
        cyc(1'b1, 1'b1, 2'd1, 2'b10, '0, 1'b0);
        cyc(1'b1, 1'b1, 2'd2, 2'b01, '0, 1'b0);
        cyc(1'b1, 1'b0, 2'd3, 2'b11, '0, 1'b0);
        // aborted begin, then a real continue write
        cyc(1'b0, 1'b0, 2'd0, 2'b11, 'h49, 1'b0);
        cyc(1'b1, 1'b0, 2'd0, 2'b00, '0, 1'b0);
        // each deselect form, continue deselect writes nothing
        for (int s = 1; s < 4; s++) cyc(1'b0, 1'b0, s[1:0], 2'b00, 'h44, 1'b0);
        repeat (4) cyc(1'b1, 1'b0, 2'd0, 2'b00, '0, 1'b0);
        // linear read wraps to its start
        cyc(1'b0, 1'b1, 2'd0, 2'b00, 'h45, 1'b0);
        repeat (4) cyc(1'b1, 1'b0, 2'd1, 2'b00, '0, 1'b0);
        cyc(1'b0, 1'b1, 2'd0, 2'b00, 'h49, 1'b0);
        cyc(1'b0, 1'b1, 2'd0, 2'b00, 'h4A, 1'b0);
        cyc(1'b1, 1'b0, 2'd0, 2'b00, '0, 1'b1);
        cyc(1'b1, 1'b0, 2'd0, 2'b00, '0, 1'b1);
        cyc(1'b1, 1'b0, 2'd0, 2'b00, '0, 1'b0);
        // held write, then reads and writes with no gap
        cyc(1'b0, 1'b0, 2'd0, 2'b00, 'h50, 1'b0);
        cyc(1'b1, 1'b0, 2'd0, 2'b00, '0, 1'b1);
        cyc(1'b0, 1'b1, 2'd0, 2'b00, 'h44, 1'b0);
        cyc(1'b0, 1'b0, 2'd0, 2'b00, 'h52, 1'b0);
        cyc(1'b0, 1'b1, 2'd0, 2'b00, 'h46, 1'b0);
        cyc(1'b0, 1'b1, 2'd3, 2'b00, 'h44, 1'b0);
        repeat (3) cyc(1'b1, 1'b0, 2'd0, 2'b00, '0, 1'b0);
        cyc(1'b0, 1'b1, 2'd0, 2'b00, 'h50, 1'b0);
        cyc(1'b0, 1'b1, 2'd0, 2'b00, 'h52, 1'b0);
        lin_n = 1'b1;
        cyc(1'b0, 1'b1, 2'd1, 2'b00, '0, 1'b0);
        repeat (2) cyc(1'b1, 1'b0, 2'd0, 2'b00, '0, 1'b0);
        cyc(1'b0, 1'b1, 2'd0, 2'b00, 'h46, 1'b0);
        repeat (3) cyc(1'b1, 1'b0, 2'd0, 2'b00, '0, 1'b0);
        lin_n = 1'b0;
        oe_n = 1'b1;
        cyc(1'b0, 1'b1, 2'd2, 2'b00, '0, 1'b0);
        repeat (2) cyc(1'b1, 1'b0, 2'd0, 2'b00, '0, 1'b0);
        cyc(1'b0, 1'b1, 2'd0, 2'b00, 'h44, 1'b0);
        cyc(1'b1, 1'b0, 2'd0, 2'b00, '0, 1'b0);
        cyc(1'b0, 1'b1, 2'd1, 2'b00, '0, 1'b0);
        oe_n = 1'b0;
        repeat (3) cyc(1'b1, 1'b0, 2'd0, 2'b00, '0, 1'b0);
        sleep_request = 1'b1;
        asleep = 1'b1;
        for (int i = 0; i < 6 && sleeping !== 1'b1; i++) cyc(1'b1, 1'b0, 2'd0, 2'b00, '0, 1'b0);
        chk({17'h0, sleeping}, 18'h1);
        // write and read while asleep are ignored
        cyc(1'b0, 1'b0, 2'd0, 2'b00, 'h44, 1'b0);
        cyc(1'b1, 1'b0, 2'd0, 2'b00, '0, 1'b0);
        cyc(1'b0, 1'b1, 2'd0, 2'b00, 'h45, 1'b0);
        cyc(1'b1, 1'b0, 2'd0, 2'b00, '0, 1'b0);
        sleep_request = 1'b0;
        repeat (5) cyc(1'b1, 1'b0, 2'd0, 2'b00, '0, 1'b0);
        chk({17'h0, sleeping}, 18'h0);
        asleep = 1'b0;
        cyc(1'b0, 1'b1, 2'd0, 2'b00, 'h44, 1'b0);
        cyc(1'b1, 1'b0, 2'd0, 2'b00, '0, 1'b0);
        // Reads hold off the drain three cycles in four, one write per four, then let it empty
        cyc(1'b0, 1'b1, 2'd1, 2'b00, '0, 1'b0);
        ck = 1'b0;
        for (int i = 0; i < 40 && buffer_ready; i++) begin
            cyc(1'b0, 1'b0, 2'd0, 2'b00, AW'(8'h80 + i), 1'b0);
            cyc(1'b0, 1'b1, 2'd0, 2'b00, 'h44, 1'b0);
            repeat (2) cyc(1'b1, 1'b0, 2'd0, 2'b00, '0, 1'b0);
        end
        for (int i = 0; i < 40 && !buffer_ready; i++) cyc(1'b0, 1'b1, 2'd1, 2'b00, '0, 1'b0);
        repeat (20) cyc(1'b1, 1'b0, 2'd0, 2'b00, '0, 1'b0);
        chk({17'h0, buffer_ready}, 18'h1);
        close_out();
    end
endmodule : test_flowthrough_sync_sram_control
